/* dv/sdr_addressing_and_init_test.sv */
// Purpose: Self-checking bench for the SDRAM device core.
// Assumes: Controller model does power-up, then the bench takes the bus.
// Notes: Row width shrunk to 4; bursts of 4, latency 3, sequential.
`timescale 1ns/10ps
`default_nettype none
`include "sdr_defines.svh"
module sdr_addressing_and_init_test;
  localparam logic [3:0] C_ACT = {1'b0, `SDR_CMD_ACT};
  localparam logic [3:0] C_RD = {1'b0, `SDR_CMD_RD};
  localparam logic [3:0] C_WR = {1'b0, `SDR_CMD_WR};
  localparam logic [3:0] C_PRE = {1'b0, `SDR_CMD_PRE};
  localparam logic [3:0] C_LMR = {1'b0, `SDR_CMD_LMR};
  localparam logic [3:0] C_NOP = 4'h7;
  typedef struct {
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [11:0] a;
    logic [3:0] open;
  } sdr_row_t;
  logic core_clk_i;
  logic rst_i;
  logic [3:0] tb_cmd;
  logic [3:0] m_cmd;
  logic [3:0] cmd;
  logic [1:0] tb_ba;
  logic [1:0] ba;
  logic [11:0] tb_addr;
  logic [11:0] m_addr;
  logic [11:0] addr;
  logic tb_lm;
  logic tb_hm;
  logic m_rdy;
  logic [15:0] tb_dq;
  logic [15:0] dout;
  logic [1:0] oe_n;
  logic [3:0] bopen;
  logic [11:0] mreg;
  logic [11:0] emreg;
  wire [15:0] dq;
  int fail_count;
  int n_checks;
  sdr_row_t rows[8];

  // Model owns the bus until it reports ready
  assign cmd = m_rdy ? tb_cmd : m_cmd;
  assign ba = m_rdy ? tb_ba : 2'b00;
  assign addr = m_rdy ? tb_addr : m_addr;
  // Shared data wire, resolved lane by lane from the device enables
  assign dq[15:8] = oe_n[1] ? tb_dq[15:8] : dout[15:8];
  assign dq[7:0] = oe_n[0] ? tb_dq[7:0] : dout[7:0];

  sdr_ctl_model u_sdr_ctl_model (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .cmd_o(m_cmd),
    .addr_o(m_addr),
    .ready_o(m_rdy)
  );

  sdr_core #(.ROW_W(4)) u_sdr_core (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .cs_n_i(cmd[3]),
    .ras_n_i(cmd[2]),
    .cas_n_i(cmd[1]),
    .we_n_i(cmd[0]),
    .bank_select_i(ba),
    .row_col_address_i(addr),
    .low_byte_mask_i(tb_lm),
    .high_byte_mask_i(tb_hm),
    .data_lines_i(dq),
    .data_lines_o(dout),
    .data_lines_oe_n_o(oe_n),
    .bank_open_o(bopen),
    .mode_reg_o(mreg),
    .ext_mode_reg_o(emreg)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // One command per cycle, changed on the falling edge
  task automatic drive(input logic [3:0] c, input logic [1:0] b,
      input logic [11:0] a, input logic [15:0] d, input logic lm,
      input logic hm);
    @(negedge core_clk_i);
    tb_cmd = c;
    tb_ba = b;
    tb_addr = a;
    tb_dq = d;
    tb_lm = lm;
    tb_hm = hm;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Write burst of four; words are base, base+1, ...
  task automatic wr4(input logic [1:0] b, input logic [11:0] a,
      input logic [15:0] base, input logic lm0);
    drive(C_WR, b, a, base, lm0, 1'b0);
    for (int k = 1; k < 4; k++) begin
      drive(C_NOP, 2'b00, 12'h000, base + 16'(k), 1'b0, 1'b0);
    end
  endtask

  // Read burst of four; hm1 masks the high lane of the second word
  task automatic rd4(input logic [1:0] b, input logic [11:0] a,
      input logic [3:0][15:0] e, input logic hm1);
    drive(C_RD, b, a, 16'hc3c3, 1'b0, 1'b0);
    drive(C_NOP, 2'b00, 12'h000, 16'hc3c3, 1'b0, hm1);
    drive(C_NOP, 2'b00, 12'h000, 16'hc3c3, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      drive(C_NOP, 2'b00, 12'h000, 16'hc3c3, 1'b0, 1'b0);
      check("read word", dq, e[k]);
      check("read enable", {14'h0000, oe_n},
          {14'h0000, (k == 1 && hm1) ? 2'b10 : 2'b00});
    end
    drive(C_NOP, 2'b00, 12'h000, 16'hc3c3, 1'b0, 1'b0);
    check("idle enable", {14'h0000, oe_n}, 16'h0003);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Free-running 100 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever begin
      #5 core_clk_i = ~core_clk_i;
    end
  end

  // Power-up wait plus about two thousand cycles of margin
  initial begin
    repeat (12000) @(posedge core_clk_i);
    fail_count++;
    $display("ERROR watchdog expected done seen timeout");
    complete_run();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_i = 1'b1;
    {tb_cmd, tb_ba, tb_addr, tb_dq, tb_lm, tb_hm} = {C_NOP, 32'h0000_0000};
    fail_count = 0;
    n_checks = 0;
    rows = '{'{C_ACT, 2'd0, 12'h005, 4'h1}, '{C_ACT, 2'd1, 12'h003, 4'h3},
      '{C_ACT, 2'd2, 12'h007, 4'h7}, '{C_ACT, 2'd3, 12'h009, 4'hf},
      '{C_PRE, 2'd2, 12'h000, 4'hb}, '{C_PRE, 2'd0, 12'h400, 4'h0},
      '{C_ACT, 2'd0, 12'h005, 4'h1}, '{C_ACT, 2'd3, 12'h009, 4'h9}};
    repeat (11) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check("reset enable", {14'h0000, oe_n}, 16'h0003);
    check("reset open", {12'h000, bopen}, 16'h0000);
    check("reset mode", {4'h0, mreg}, 16'h0000);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 10100 && m_rdy !== 1'b1; i++) begin
      @(posedge core_clk_i);
    end
    check("mode after power-up", {4'h0, mreg}, 16'h0032);
    // Bank code selects which mode register loads; 01 is ignored
    drive(C_LMR, 2'b10, 12'h025, 16'h0000, 1'b0, 1'b0);
    drive(C_LMR, 2'b01, 12'h7ff, 16'h0000, 1'b0, 1'b0);
    drive(C_NOP, 2'b00, 12'h000, 16'h0000, 1'b0, 1'b0);
    check("ext mode", {4'h0, emreg}, 16'h0025);
    check("base mode", {4'h0, mreg}, 16'h0032);
    // Opening and closing rows, single and all-bank precharge
    foreach (rows[i]) begin
      drive(rows[i].cmd, rows[i].ba, rows[i].a, 16'h0000, 1'b0, 1'b0);
      drive(C_NOP, 2'b00, 12'h000, 16'h0000, 1'b0, 1'b0);
      check("bank open", {12'h000, bopen}, {12'h000, rows[i].open});
    end
    // Burst starting mid-block wraps; only open rows are used
    wr4(2'd0, 12'h002, 16'h1100, 1'b0);
    rd4(2'd0, 12'h000, {16'h1101, 16'h1100, 16'h1103, 16'h1102}, 1'b0);
    // Masked first word with auto precharge closes bank 0 afterwards
    wr4(2'd0, 12'h400, 16'hab10, 1'b1);
    drive(C_NOP, 2'b00, 12'h000, 16'h0000, 1'b0, 1'b0);
    drive(C_NOP, 2'b00, 12'h000, 16'h0000, 1'b0, 1'b0);
    check("auto precharge", {12'h000, bopen}, 16'h0008);
    drive(C_ACT, 2'd0, 12'h005, 16'h0000, 1'b0, 1'b0);
    drive(C_NOP, 2'b00, 12'h000, 16'h0000, 1'b0, 1'b0);
    rd4(2'd0, 12'h000, {16'hab13, 16'hab12, 16'hc311, 16'hab02}, 1'b1);
    // Interleaved order, single-location writes; banks idle for the load
    drive(C_PRE, 2'd0, 12'h400, 16'h0000, 1'b0, 1'b0);
    drive(C_LMR, 2'd0, 12'h23a, 16'h0000, 1'b0, 1'b0);
    drive(C_ACT, 2'd0, 12'h005, 16'h0000, 1'b0, 1'b0);
    check("mode reload", {4'h0, mreg}, 16'h023a);
    drive(C_WR, 2'd0, 12'h001, 16'h5a5a, 1'b0, 1'b0);
    drive(C_NOP, 2'b00, 12'h000, 16'h7777, 1'b0, 1'b0);
    drive(C_NOP, 2'b00, 12'h000, 16'h0000, 1'b0, 1'b0);
    rd4(2'd0, 12'h001, {16'hab12, 16'hab13, 16'hab02, 16'h5a5a}, 1'b0);
    // Reset in mid-run clears banks, both mode registers and bus drive
    @(negedge core_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    check("mid reset open", {12'h000, bopen}, 16'h0000);
    check("mid reset mode", {4'h0, mreg}, 16'h0000);
    check("mid reset ext", {4'h0, emreg}, 16'h0000);
    check("mid reset enable", {14'h0000, oe_n}, 16'h0003);
    complete_run();
  end
endmodule
`default_nettype wire

/* dv/sdr_ctl_model.sv */
// Purpose: Controller stand-in that powers the device up in fixed order.
// Assumes: Shares core_clk_i with the device; drives on the falling edge.
// Notes: ready_o hands the command bus over to the bench.
`timescale 1ns/10ps
`default_nettype none
`include "sdr_defines.svh"
module sdr_ctl_model #(
  parameter int WAIT_CYC = 10000,
  parameter logic [11:0] MODE = 12'h032
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  output logic [3:0] cmd_o,
  output logic [11:0] addr_o,
  output logic ready_o
);
  int step_r;

  // ****************************************************************
  // Power-up walk; counted from reset so a new reset restarts it
  // ****************************************************************
  // One process owns the bus; quiet at time zero, one write per edge
  initial begin
    cmd_o = 4'hf;
    addr_o = 12'h000;
    ready_o = 1'b0;
    step_r = 0;
    forever begin
      @(negedge core_clk_i);
      if (rst_i) begin
        step_r <= 0;
        ready_o <= 1'b0;
        cmd_o <= 4'hf;
        addr_o <= 12'h000;
      end else begin
        step_r <= step_r + 1;
        if (step_r == WAIT_CYC) begin // Nothing real before the wait
          cmd_o <= {1'b0, `SDR_CMD_PRE};
          addr_o <= 12'h400;
        end else if (step_r == WAIT_CYC + 2 ||
            step_r == WAIT_CYC + 4) begin
          cmd_o <= {1'b0, `SDR_CMD_REF};
          addr_o <= 12'h000;
        end else if (step_r == WAIT_CYC + 6) begin // Banks idle
          cmd_o <= {1'b0, `SDR_CMD_LMR};
          addr_o <= MODE;
        end else begin
          cmd_o <= 4'hf; // Inhibit whenever nothing else is due
          addr_o <= 12'h000;
        end
        if (step_r == WAIT_CYC + 9) begin // Gap after mode load
          ready_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* logic/sdr_buf.sv */
// Purpose: Two-entry buffer for read words on their way to the pins.
// Assumes: Synchronous active-high reset.
// Notes: out_data comes straight from a flop.
`timescale 1ns/10ps
`default_nettype none
module sdr_buf (
  input wire logic core_clk_i,
  input wire logic rst_i,
  sdr_buf_if.buffer bq
);
  logic [1:0] cnt_r;
  logic [$bits(bq.out_data)-1:0] e0_r;
  logic [$bits(bq.out_data)-1:0] e1_r;
  logic push;
  logic pop;

  // Full and empty come from the occupancy count
  assign bq.in_ready = (cnt_r != 2'd2);
  assign bq.out_valid = (cnt_r != 2'd0);
  assign bq.out_data = e0_r;
  assign push = bq.in_valid && bq.in_ready;
  assign pop = bq.out_valid && bq.out_ready;

  // Occupancy
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_r <= 2'd0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + 2'd1;
    end else if (pop && !push) begin
      cnt_r <= cnt_r - 2'd1;
    end
  end

  // Entry shuffle; head always in e0
  always_ff @(posedge core_clk_i) begin
    if (pop) begin
      e0_r <= (push && cnt_r == 2'd1) ? bq.in_data : e1_r;
      if (push && cnt_r == 2'd2) begin
        e1_r <= bq.in_data;
      end
    end else if (push) begin
      if (cnt_r == 2'd0) begin
        e0_r <= bq.in_data;
      end else begin
        e1_r <= bq.in_data;
      end
    end
  end
endmodule
`default_nettype wire

/* logic/sdr_core.sv */
// Purpose: Four-bank SDRAM device: decode, banks, mode, array, data bus.
// Assumes: Controller runs on core_clk_i; no input synchronisers needed.
// Notes: Array is behavioural; shrink ROW_W for simulation.
`timescale 1ns/10ps
`default_nettype none
`include "sdr_defines.svh"
module sdr_core
  import sdr_pkg::*;
#(
  parameter int ROW_W = 12
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [1:0] bank_select_i,
  input wire logic [11:0] row_col_address_i,
  input wire logic low_byte_mask_i,
  input wire logic high_byte_mask_i,
  input wire logic [15:0] data_lines_i,
  output logic [15:0] data_lines_o,
  output logic [1:0] data_lines_oe_n_o,
  output logic [3:0] bank_open_o,
  output logic [11:0] mode_reg_o,
  output logic [11:0] ext_mode_reg_o
);
  localparam int AW = 2 + ROW_W + `SDR_COL_W;

  // ****************************************************************
  // Decode and mode
  // ****************************************************************
  sdr_cmd_t cmd;
  logic [1:0] blc;
  logic il;
  logic [3:0] bl_len;
  logic [15:0] mem_r [0:(1 << AW)-1];
  logic [ROW_W-1:0] row_r [0:3];
  logic [11:0] mode_r;
  logic [11:0] ext_r;
  logic [3:0] open_r;
  logic [1:0] msk;

  // Inputs are taken as they stand at the rising edge
  assign cmd = sdr_decode(cs_n_i, {ras_n_i, cas_n_i, we_n_i});
  assign blc = mode_r[`SDR_BL_LSB +: 2];
  assign il = mode_r[`SDR_BT_BIT];
  assign bl_len = 4'(4'd1 << blc);
  assign msk = {high_byte_mask_i, low_byte_mask_i};

  // Mode load steered by bank select, op-code from the address
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_r <= `SDR_MODE_RST;
      ext_r <= `SDR_MODE_RST;
    end else if (cmd == SDR_LMR) begin
      if (bank_select_i == `SDR_BA_MODE) begin
        mode_r <= row_col_address_i;
      end else if (bank_select_i == `SDR_BA_EXT) begin
        ext_r <= row_col_address_i;
      end
    end
  end

  // ****************************************************************
  // Write path
  // ****************************************************************
  logic wr_act_r;
  logic [3:0] wr_idx_r;
  logic [3:0] wr_len_r;
  logic [1:0] wr_bank_r;
  logic [7:0] wr_col_r;
  logic wr_ap_r;
  logic wr_now;
  logic [1:0] w_bank;
  logic [7:0] w_col;
  logic [AW-1:0] wa;
  logic [3:0] wr_len;
  logic wr_end;

  // Single-location writes when write burst mode is set
  assign wr_len = mode_r[`SDR_WB_BIT] ? 4'd1 : bl_len;
  assign wr_now = (cmd == SDR_WR) || (wr_act_r && cmd == SDR_NOP);
  assign w_bank = (cmd == SDR_WR) ? bank_select_i : wr_bank_r;
  assign w_col = (cmd == SDR_WR) ? row_col_address_i[7:0]
               : sdr_burst_col(wr_col_r, wr_idx_r[2:0], blc, il);
  assign wa = {w_bank, row_r[w_bank], w_col};
  assign wr_end = (cmd == SDR_WR) ? (wr_len == 4'd1)
                : (wr_act_r && wr_idx_r == wr_len_r - 4'd1);

  // Array write; a high byte mask keeps that lane untouched
  always_ff @(posedge core_clk_i) begin
    if (wr_now && !low_byte_mask_i) begin
      mem_r[wa][7:0] <= data_lines_i[7:0];
    end
    if (wr_now && !high_byte_mask_i) begin
      mem_r[wa][15:8] <= data_lines_i[15:8];
    end
  end

  // Write burst progress; any other command cuts the burst short
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_act_r <= 1'b0;
      wr_idx_r <= 4'd0;
      wr_len_r <= 4'd1;
      wr_bank_r <= 2'd0;
      wr_col_r <= 8'h00;
      wr_ap_r <= 1'b0;
    end else if (cmd == SDR_WR) begin
      wr_act_r <= (wr_len != 4'd1);
      wr_idx_r <= 4'd1;
      wr_len_r <= wr_len;
      wr_bank_r <= bank_select_i;
      wr_col_r <= row_col_address_i[7:0];
      wr_ap_r <= row_col_address_i[`SDR_AP_BIT];
    end else if (wr_now && !wr_end) begin
      wr_idx_r <= wr_idx_r + 4'd1;
    end else begin
      wr_act_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  sdr_buf_if #(.W(`SDR_DQ_W)) bq ();
  logic rd_act_r;
  logic [3:0] rd_idx_r;
  logic [3:0] rd_len_r;
  logic [1:0] rd_bank_r;
  logic [7:0] rd_col_r;
  logic rd_ap_r;
  logic [2:0] lat_r;
  logic rd_push;
  logic rd_end;
  logic [1:0] mq_d1_r;
  logic [1:0] mq_d2_r;
  logic [15:0] dq_r;
  logic [1:0] oe_n_r;

  sdr_buf u_buf (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .bq(bq.buffer)
  );

  // Beats are fetched only while the buffer has room
  assign bq.in_valid = rd_act_r;
  assign bq.in_data = mem_r[{rd_bank_r, row_r[rd_bank_r],
    sdr_burst_col(rd_col_r, rd_idx_r[2:0], blc, il)}];
  assign rd_push = bq.in_valid && bq.in_ready;
  assign rd_end = rd_push && (rd_idx_r == rd_len_r - 4'd1);
  // Drain opens one edge before CAS latency expires
  assign bq.out_ready = (lat_r <= 3'd2);

  // Read burst progress and latency count
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_act_r <= 1'b0;
      rd_idx_r <= 4'd0;
      rd_len_r <= 4'd1;
      rd_bank_r <= 2'd0;
      rd_col_r <= 8'h00;
      rd_ap_r <= 1'b0;
      lat_r <= 3'd0;
    end else if (cmd == SDR_RD) begin
      rd_act_r <= 1'b1;
      rd_idx_r <= 4'd0;
      rd_len_r <= bl_len;
      rd_bank_r <= bank_select_i;
      rd_col_r <= row_col_address_i[7:0];
      rd_ap_r <= row_col_address_i[`SDR_AP_BIT];
      lat_r <= mode_r[`SDR_CL_LSB +: 3];
    end else begin
      if (cmd == SDR_BT || cmd == SDR_WR || rd_end) begin
        rd_act_r <= 1'b0;
      end
      if (rd_push) begin
        rd_idx_r <= rd_idx_r + 4'd1;
      end
      if (lat_r != 3'd0) begin
        lat_r <= lat_r - 3'd1;
      end
    end
  end

  // Mask reaches the output drivers two clocks after sampling
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mq_d1_r <= 2'b00;
      mq_d2_r <= 2'b00;
    end else begin
      mq_d1_r <= msk;
      mq_d2_r <= mq_d1_r;
    end
  end

  // Output register; lanes float when idle or masked
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dq_r <= 16'h0000;
      oe_n_r <= 2'b11;
    end else if (bq.out_valid && bq.out_ready) begin
      dq_r <= bq.out_data;
      oe_n_r <= mq_d2_r;
    end else begin
      oe_n_r <= 2'b11;
    end
  end

  assign data_lines_o = dq_r;
  assign data_lines_oe_n_o = oe_n_r;

  // ****************************************************************
  // Bank state
  // ****************************************************************

  // Open row per bank; only ACTIVE moves it
  always_ff @(posedge core_clk_i) begin
    if (cmd == SDR_ACT) begin
      row_r[bank_select_i] <= row_col_address_i[ROW_W-1:0];
    end
  end

  // Bank open flags; auto precharge closes at burst end, but an ACTIVE
  // in the same cycle comes last so the set wins over that close
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      open_r <= 4'h0;
    end else begin
      if (wr_now && wr_end && ((cmd == SDR_WR) ?
          row_col_address_i[`SDR_AP_BIT] : wr_ap_r)) begin
        open_r[w_bank] <= 1'b0;
      end
      if (rd_end && rd_ap_r) begin
        open_r[rd_bank_r] <= 1'b0;
      end
      if (cmd == SDR_ACT) begin
        open_r[bank_select_i] <= 1'b1;
      end else if (cmd == SDR_PRE) begin
        if (row_col_address_i[`SDR_AP_BIT]) begin
          open_r <= 4'h0;
        end else begin
          open_r[bank_select_i] <= 1'b0;
        end
      end
    end
  end

  assign bank_open_o = open_r;
  assign mode_reg_o = mode_r;
  assign ext_mode_reg_o = ext_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_bank_open_row: assert property (cmd == SDR_ACT |=>
    bank_open_o[$past(bank_select_i)] && row_r[$past(bank_select_i)]
    == $past(row_col_address_i[ROW_W-1:0])) else $error("row not open");
  a_precharge_all: assert property (cmd == SDR_PRE &&
    row_col_address_i[`SDR_AP_BIT] |=> bank_open_o == 4'h0)
    else $error("banks left open");
  a_precharge_one: assert property (cmd == SDR_PRE &&
    !row_col_address_i[`SDR_AP_BIT] |=> !bank_open_o[$past(bank_select_i)])
    else $error("bank left open");
  a_mode_base_load: assert property (cmd == SDR_LMR &&
    bank_select_i == `SDR_BA_MODE |=> mode_reg_o == $past(row_col_address_i))
    else $error("mode not loaded");
  a_mode_ext_load: assert property (cmd == SDR_LMR &&
    bank_select_i == `SDR_BA_EXT |=> ext_mode_reg_o ==
    $past(row_col_address_i) && $stable(mode_reg_o))
    else $error("ext mode wrong");
  a_read_col_take: assert property (cmd == SDR_RD |=> rd_act_r &&
    rd_col_r == $past(row_col_address_i[7:0]) &&
    rd_bank_r == $past(bank_select_i)) else $error("column not taken");
  a_read_mask_float: assert property (msk[1] |->
    ##3 data_lines_oe_n_o[1]) else $error("masked high lane driven");
  a_read_mask_low: assert property (msk[0] |->
    ##3 data_lines_oe_n_o[0]) else $error("masked low lane driven");
  a_drive_cause: assert property (data_lines_oe_n_o != 2'b11 |->
    $past(bq.out_valid && bq.out_ready) && $past(lat_r) <= 3'd2)
    else $error("bus driven without read");
  a_write_store: assert property (cmd == SDR_WR && msk == 2'b00 |=>
    mem_r[$past(wa)] == $past(data_lines_i)) else $error("write lost");
endmodule
`default_nettype wire

/* pkg/sdr_buf_if.sv */
// Purpose: Valid/ready carrier between read path and its skid buffer.
// Assumes: One clock for both sides.
// Notes: Fill side pushes, drain side pops.
`timescale 1ns/10ps
`default_nettype none
interface sdr_buf_if #(parameter int W = 16);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport buffer (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

/* pkg/sdr_defines.svh */
// Purpose: Constants for the four-bank SDRAM device core.
// Assumes: Controller logic shares core_clk_i with the device.
// Notes: Offsets, field positions and codes only; no logic here.
`ifndef SDR_DEFINES_SVH
`define SDR_DEFINES_SVH

// Command codes on {ras_n, cas_n, we_n} with chip select low
`define SDR_CMD_LMR 3'h0
`define SDR_CMD_REF 3'h1
`define SDR_CMD_PRE 3'h2
`define SDR_CMD_ACT 3'h3
`define SDR_CMD_WR 3'h4
`define SDR_CMD_RD 3'h5
`define SDR_CMD_BT 3'h6

// Address and mode register field positions
`define SDR_AP_BIT 10
`define SDR_BL_LSB 0
`define SDR_BT_BIT 3
`define SDR_CL_LSB 4
`define SDR_WB_BIT 9
`define SDR_COL_W 8
`define SDR_DQ_W 16

// Bank select codes during a mode load
`define SDR_BA_MODE 2'h0
`define SDR_BA_EXT 2'h2
`define SDR_MODE_RST 12'h000

`endif

/* pkg/sdr_pkg.sv */
// Purpose: Types and shared helpers of the SDRAM device core.
// Assumes: sdr_defines.svh provides the command codes.
// Notes: Burst ordering lives here so both data paths agree.
`default_nettype none
`include "sdr_defines.svh"
package sdr_pkg;

  typedef enum logic [2:0] {
    SDR_NOP, SDR_ACT, SDR_RD, SDR_WR, SDR_PRE, SDR_REF, SDR_LMR, SDR_BT
  } sdr_cmd_t;

  // Command decode; a deselected device sees NOP
  function automatic sdr_cmd_t sdr_decode(logic cs_n, logic [2:0] rcw);
    if (cs_n) begin
      return SDR_NOP;
    end
    case (rcw)
      `SDR_CMD_LMR: return SDR_LMR;
      `SDR_CMD_REF: return SDR_REF;
      `SDR_CMD_PRE: return SDR_PRE;
      `SDR_CMD_ACT: return SDR_ACT;
      `SDR_CMD_WR: return SDR_WR;
      `SDR_CMD_RD: return SDR_RD;
      `SDR_CMD_BT: return SDR_BT;
      default: return SDR_NOP;
    endcase
  endfunction

  // Column of beat idx, wrapping inside the burst block
  function automatic logic [7:0] sdr_burst_col(logic [7:0] st,
      logic [2:0] idx, logic [1:0] blc, logic il);
    logic [7:0] msk;
    logic [7:0] ofs;
    msk = 8'((8'h01 << blc) - 8'h01);
    ofs = il ? (st ^ {5'h00, idx}) : 8'(st + {5'h00, idx});
    return (st & ~msk) | (ofs & msk);
  endfunction

endpackage
`default_nettype wire
